// file: perf_event_consts.vh
// Purpose: Constants for the performance event source selector.
// Assumes: Event codes are six bits wide.
// Notes: Definitions only.
`ifndef PERF_EVENT_CONSTS_VH
`define PERF_EVENT_CONSTS_VH
`define EVT_CODE_W 6
`define EVT_FP_OP 6'h22
`define EVT_BP_MATCH0 6'h23
`define EVT_BP_MATCH1 6'h24
`define EVT_BP_MATCH2 6'h25
`define EVT_BP_MATCH3 6'h26
`define EVT_HW_IRQ 6'h27
`define EVT_DATA_ACCESS 6'h28
`define FP_OPS_W 3
`define INC_W 3
`define BP_COUNT 4
`define INC_RST 3'h0
`define BP_PINS_RST 4'h0
`endif

// file: data_access_qualifier.v
// Purpose: Qualifies one pipe's data access report for the access count.
// Assumes: Inputs come from same-clock pipeline logic.
// Notes: One instance per pipe.
`timescale 1ns/1ps
module data_access_qualifier (
  input wire accessValid,
  input wire accessIsIo,
  input wire accessTlbWalk,
  input wire accessIsWrite,
  output wire accessCounts
);
  // Split halves arrive as separate accesses, so each half counts once.
  // Page walk reads and every I/O access are left out.
  assign accessCounts = accessValid & ~accessIsIo &
                        ~(accessTlbWalk & ~accessIsWrite); // R13
endmodule

// file: perf_event_source_select.v
// Purpose: Selects and qualifies event sources for a performance counter.
// Assumes: All event inputs are synchronous pulses on mclk from core logic.
// Notes: The increment output is registered; it lags its events by one cycle.
// Notes on behaviour
// R01 - Code 22H counts each floating-point add, subtract, multiply, divide, remainder and root.
// R02 - A transcendental instruction counts once per internal add and multiply it performs.
// R03 - Ops raising divide-by-zero, negative root, special operand or stack faults are dropped.
// R04 - Operations raising any other floating-point exception still count.
// R05 - Integer multiplies and other floating-point-unit instructions also count.
// R06 - Codes 23H to 26H count matches on debug address registers zero to three.
// R07 - Breakpoint matches count whether or not the breakpoint is enabled; the code drops second-pipe code matches while breakpoints are off.
// R08 - With breakpoints disabled, second-pipe code matches never count.
// R09 - Each match event coincides with the matching bit of the breakpoint match pins.
// R10 - Code 27H counts taken maskable and non-maskable hardware interrupts.
// R11 - Code 28H counts memory data reads and writes, cache hit or miss.
// R12 - Each cycle of a split access counts once.
// R13 - Page walk reads and all I/O accesses are left out of the data access count.
// R14 - Up to two data access events are added in one clock.
// R15 - Each clock the count of the selected source is added and all others are ignored.
`timescale 1ns/1ps
`include "perf_event_consts.vh"
module perf_event_source_select (
  input wire mclk,
  input wire rst_n,
  input wire [`EVT_CODE_W-1:0] eventCode,
  input wire [`FP_OPS_W-1:0] fpOpCount,
  input wire fpOpIsUnitInstr,
  input wire fpFaultDivZero,
  input wire fpFaultNegSqrt,
  input wire fpFaultSpecialOperand,
  input wire fpFaultStack,
  input wire [`BP_COUNT-1:0] bpMatchPipe1,
  input wire [`BP_COUNT-1:0] bpMatchPipe2,
  input wire [`BP_COUNT-1:0] bpMatchPipe2IsCode,
  input wire breakpointsEnabled,
  input wire maskableIrqTaken,
  input wire nmiTaken,
  input wire [1:0] dataAccessValid,
  input wire [1:0] dataAccessIsIo,
  input wire [1:0] dataAccessTlbWalk,
  input wire [1:0] dataAccessIsWrite,
  output reg [`BP_COUNT-1:0] breakpoint_match_pins,
  output reg [`INC_W-1:0] counterIncrement
);
  wire fpExcluded;
  wire [`INC_W-1:0] fpInc;
  wire [`BP_COUNT-1:0] bpMatch;
  wire [1:0] dataCounts;
  wire [`INC_W-1:0] irqInc;
  wire [`INC_W-1:0] dataInc;
  reg [`INC_W-1:0] nxt_counterIncrement;
  reg [`BP_COUNT-1:0] nxt_bpPins;

  // fpOpCount carries several internal operations for transcendentals.
  // Faults other than the four excluded kinds do not block the count.
  assign fpExcluded = fpFaultDivZero | fpFaultNegSqrt |
                      fpFaultSpecialOperand | fpFaultStack; // R03
  assign fpInc = fpExcluded ? {`INC_W{1'b0}} :
                 (fpOpIsUnitInstr ? fpOpCount : {`INC_W{1'b0}}); // R01 R02 R04 R05

  genvar gi;
  generate
    for (gi = 0; gi < `BP_COUNT; gi = gi + 1) begin : bp_gen
      // Second-pipe code matches are dropped while breakpoints are off.
      assign bpMatch[gi] = bpMatchPipe1[gi] |
                           (bpMatchPipe2[gi] &
                            (breakpointsEnabled | ~bpMatchPipe2IsCode[gi])); // R07 R08
    end
    for (gi = 0; gi < 2; gi = gi + 1) begin : da_gen
      data_access_qualifier u_qual (
        .accessValid(dataAccessValid[gi]),
        .accessIsIo(dataAccessIsIo[gi]),
        .accessTlbWalk(dataAccessTlbWalk[gi]),
        .accessIsWrite(dataAccessIsWrite[gi]),
        .accessCounts(dataCounts[gi])
      );
    end
  endgenerate

  // Two one-bit events in one cycle give an increment of zero to two.
  function [`INC_W-1:0] pair_sum(input a, input b);
    pair_sum = {{(`INC_W-2){1'b0}}, a & b, a ^ b};
  endfunction

  function [`INC_W-1:0] bit_inc(input a);
    bit_inc = {{(`INC_W-1){1'b0}}, a};
  endfunction

  assign irqInc = pair_sum(maskableIrqTaken, nmiTaken); // R10
  assign dataInc = pair_sum(dataCounts[1], dataCounts[0]); // R11 R12 R14

  always @* begin
    nxt_bpPins = bpMatch;
    case (eventCode) // R15
      `EVT_FP_OP: nxt_counterIncrement = fpInc;
      `EVT_BP_MATCH0: nxt_counterIncrement = bit_inc(bpMatch[0]); // R06
      `EVT_BP_MATCH1: nxt_counterIncrement = bit_inc(bpMatch[1]); // R06
      `EVT_BP_MATCH2: nxt_counterIncrement = bit_inc(bpMatch[2]); // R06
      `EVT_BP_MATCH3: nxt_counterIncrement = bit_inc(bpMatch[3]); // R06
      `EVT_HW_IRQ: nxt_counterIncrement = irqInc;
      `EVT_DATA_ACCESS: nxt_counterIncrement = dataInc;
      default: nxt_counterIncrement = {`INC_W{1'b0}};
    endcase
  end

  // Pins and increment register together so a match and its count align.
  always @(posedge mclk) begin
    if (!rst_n) begin
      counterIncrement <= `INC_RST;
      breakpoint_match_pins <= `BP_PINS_RST;
    end else begin
      counterIncrement <= nxt_counterIncrement; // R15
      breakpoint_match_pins <= nxt_bpPins; // R09
    end
  end
endmodule

// file: core_event_model.sv
// Purpose: Random model of the core logic that raises event pulses.
// Assumes: Every event is a one-cycle pulse sampled on mclk.
// Notes: The bench splits ev into the selector's event inputs.
`timescale 1ns/1ps
module core_event_model (
  input wire logic mclk,
  output logic [30:0] ev
);
  // The seed is set once in the process that draws the stimulus, so every run repeats.
  initial begin
    ev = 31'h0;
    void'($urandom(11));
    forever @(posedge mclk) ev <= 31'($urandom);
  end
endmodule

// file: perf_event_source_select_properties.sv
// Purpose: Port-level properties of the event source selector.
// Assumes: One clock domain with a synchronous reset.
// Notes: Both outputs lag their causes by one cycle.
`timescale 1ns/1ps
module perf_event_source_select_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fpOpIsUnitInstr,
  input wire logic fpFaultStack,
  input wire logic breakpointsEnabled,
  input wire logic maskableIrqTaken,
  input wire logic nmiTaken,
  input wire logic [5:0] eventCode,
  input wire logic [2:0] counterIncrement,
  input wire logic [3:0] bpMatchPipe1,
  input wire logic [3:0] bpMatchPipe2IsCode,
  input wire logic [3:0] breakpoint_match_pins,
  input wire logic [1:0] dataAccessValid,
  input wire logic [1:0] dataAccessIsIo,
  input wire logic [1:0] dataAccessIsWrite
);
  wire [5:0] c = eventCode;
  wire [2:0] n = counterIncrement;
  wire [1:0] irq = maskableIrqTaken + nmiTaken;
  wire twoOk = dataAccessValid == 2'h3 && dataAccessIsIo == 2'h0 &&
    dataAccessIsWrite == 2'h3;
  wire vOnly = !breakpointsEnabled && bpMatchPipe1 == 4'h0 && bpMatchPipe2IsCode == 4'hF;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // The reset is synchronous, so a check starts only where rst_n is sampled high.
  a_irq_sum: assert property (rst_n && c == 6'h27 |=> n == $past(irq))
    else $error("irq");
  a_unsel_zero: assert property (rst_n && !(c inside {[6'h22:6'h28]}) |=> n == 3'h0)
    else $error("unsel");
  a_io_drop: assert property (rst_n && c == 6'h28 && dataAccessIsIo == 2'h3 |=> !n)
    else $error("io");
  a_two_access: assert property (rst_n && c == 6'h28 && twoOk |=> n == 3'h2)
    else $error("two");
  a_fault_drop: assert property (rst_n && c == 6'h22 && fpFaultStack |=> !n)
    else $error("flt");
  a_unit_gate: assert property (rst_n && c == 6'h22 && !fpOpIsUnitInstr |=> !n)
    else $error("unit");
  a_bp_pipe1: assert property (rst_n && bpMatchPipe1 != 4'h0 |=>
    (breakpoint_match_pins & $past(bpMatchPipe1)) == $past(bpMatchPipe1)) else $error("bp");
  a_bp_vpipe: assert property (rst_n && vOnly |=> breakpoint_match_pins == 4'h0)
    else $error("v");
  c_two: cover property (n == 3'h2);
  c_three: cover property (n == 3'h3);
  c_bp: cover property (breakpoint_match_pins != 4'h0);
endmodule

// file: perf_event_source_select_test.sv
// Purpose: Self-checking bench for the event source selector.
// Assumes: Event pulses come from the random core model.
// Notes: Tests 0 to 9 hold codes 20H to 29H; the last test mixes codes.
`timescale 1ns/1ps
module perf_event_source_select_test;
  logic mclk, rst_n;
  logic [5:0] eventCode;
  logic [2:0] inc, e;
  logic [3:0] pins, bp;
  logic [1:0] d;
  logic [30:0] ev;
  logic [6:0] q[$];
  int miscompares, checked;
  core_event_model i_core (.mclk(mclk), .ev(ev));
  perf_event_source_select i_dut (.mclk(mclk), .rst_n(rst_n), .eventCode(eventCode),
    .fpOpCount(ev[2:0]), .fpOpIsUnitInstr(ev[3]), .fpFaultDivZero(ev[4]),
    .fpFaultNegSqrt(ev[5]), .fpFaultSpecialOperand(ev[6]), .fpFaultStack(ev[7]),
    .bpMatchPipe1(ev[11:8]), .bpMatchPipe2(ev[15:12]), .bpMatchPipe2IsCode(ev[19:16]),
    .breakpointsEnabled(ev[20]), .maskableIrqTaken(ev[21]), .nmiTaken(ev[22]),
    .dataAccessValid(ev[24:23]), .dataAccessIsIo(ev[26:25]), .dataAccessTlbWalk(ev[28:27]),
    .dataAccessIsWrite(ev[30:29]), .breakpoint_match_pins(pins), .counterIncrement(inc));
  task chk(string nm, logic [3:0] seen, logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Notes the result that the inputs sampled at this edge must give at the next falling edge.
  always @(posedge mclk) begin
    bp = ev[11:8] | ev[15:12] & ~(ev[19:16] & ~{4{ev[20]}});
    d = ev[24:23] & ~ev[26:25] & ~(ev[28:27] & ~ev[30:29]);
    e = 3'h0;
    if (eventCode == 6'h22 && ev[3] && ev[7:4] == 4'h0) e = ev[2:0];
    if (eventCode inside {[6'h23:6'h26]}) e = 3'(bp[eventCode[1:0] + 2'h1]);
    if (eventCode == 6'h27) e = 3'(ev[21]) + 3'(ev[22]);
    if (eventCode == 6'h28) e = 3'(d[0]) + 3'(d[1]);
    q.push_back(rst_n ? {bp, e} : 7'h0);
  end
  always @(negedge mclk) if (q.size() > 0) begin
    chk("pins", pins, q[0][6:3]);
    chk("increment", inc, q[0][2:0]);
    void'(q.pop_front());
  end
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #40000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    rst_n = 0;
    eventCode = 6'h0;
    repeat (8) @(posedge mclk);
    for (int t = 0; t < 11; t++) begin
      rst_n <= 1;
      repeat (200) @(posedge mclk) eventCode <= 6'h20 + 6'(t < 10 ? t : ev[30:27] % 10);
      rst_n <= 0;
      @(posedge mclk);
      $display("Test %0d done", t);
    end
    report_and_stop;
  end
endmodule
bind perf_event_source_select perf_event_source_select_checker i_chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .fpOpIsUnitInstr(fpOpIsUnitInstr),
  .fpFaultStack(fpFaultStack),
  .breakpointsEnabled(breakpointsEnabled),
  .maskableIrqTaken(maskableIrqTaken),
  .nmiTaken(nmiTaken),
  .eventCode(eventCode),
  .counterIncrement(counterIncrement),
  .bpMatchPipe1(bpMatchPipe1),
  .bpMatchPipe2IsCode(bpMatchPipe2IsCode),
  .breakpoint_match_pins(breakpoint_match_pins),
  .dataAccessValid(dataAccessValid),
  .dataAccessIsIo(dataAccessIsIo),
  .dataAccessIsWrite(dataAccessIsWrite)
);
